// File: etseq_pkg.sv
// Constants, register map and field layout of the event timer sequencer.
// Assumes a 10 MHz clock and an AXI4-Lite master with an 8-bit byte address.
// Functional notes
// RL1: Up to sixteen steps numbered 1 to 16; a program may stop earlier.
// RL2: Sixteen outputs 0 to 15 follow word bits; set bit means on.
// RL3: Bit-to-output mapping is common; each step holds its own pattern.
// RL4: Each step has its own condition: time, event, or both.
// RL5: One timebase, 0.01 s to 99.99 s per tick, shared by every step.
// RL6: Dwell equals 0.01 s times timebase times the step's own count.
// RL7: Timebase and per-step count accept values up to 9999.
// RL8: Evaluation happens once per scan; ticks and step changes only on scan strobe.
// RL9: Time-only step stays until its counts elapse, then next criteria apply.
// RL10: On entry the step pattern is applied, then its event is sampled.
// RL11: Step event selectable from input, output or internal relay points.
// RL12: Time-and-event step times only while event true, else stays put.
// RL13: When the step count expires the sequencer moves to the next step.
// RL14: Outputs switch to the new pattern in the same evaluation.
// RL15: Preset moves the current step directly to any chosen step number.
// RL16: Preset step 1..16 is loaded while reset is on and on run entry.
// RL17: Reset overrides start; start off freezes; start on runs timer and events.
// RL18: Each jog off-to-on edge advances one step while reset off, any start.
// RL19: After last step: set done, hold pattern, ignore start and jog until reset.
// RL20: Prescaler and count timer clear on every step entry.
// RL21: No count means advance on event; no event means count unconditionally.
package etseq_pkg;
   localparam int ADDR_W = 8;
   localparam int NUM_STEPS = 16;
   localparam int NUM_OUTS = 16;
   localparam int NUM_POINTS = 16;
   localparam int VAL_W = 14;
   localparam logic [VAL_W-1:0] VAL_MAX = 14'h270F;

   // One timer count is a hundredth of a second; the scan runs at that rate
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_TIME_NS = 10000000;
   localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_TIMEBASE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PRESET = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_LAST = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STEPCNT = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_RELAY = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_INPUTS = 8'h20;
   localparam logic [1:0] PAGE_PATTERN = 2'h1;
   localparam logic [1:0] PAGE_STEPCFG = 2'h2;

   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_JOG_BIT = 1;
   localparam int CTRL_RESET_BIT = 2;
   localparam int CTRL_RUN_BIT = 3;
   localparam int STAT_DONE_BIT = 8;
   localparam int CFG_USECNT_BIT = 16;
   localparam int CFG_USEEV_BIT = 17;
   localparam int CFG_EVIDX_LSB = 24;
   localparam int CFG_EVTYPE_LSB = 28;
   localparam logic [31:0] CFG_MASK = 32'h3F03_3FFF;

   localparam logic [1:0] EV_INPUT = 2'h0;
   localparam logic [1:0] EV_OUTPUT = 2'h1;
   localparam logic [1:0] EV_RELAY = 2'h2;

   localparam logic [3:0] RST_CTRL = 4'h0;
   localparam logic [VAL_W-1:0] RST_TIMEBASE = 14'h0064;
   localparam logic [3:0] RST_PRESET = 4'h0;
   localparam logic [3:0] RST_LAST = 4'hF;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {SEQ_STEP, SEQ_DONE} seq_state_e;
endpackage : etseq_pkg

// File: scan_divider.sv
// Scan strobe generator: one-cycle pulse every CYCLES clocks.
// Assumes a free-running clock; the strobe paces every sequencer evaluation.
`timescale 1ns/1ps
module scan_divider #(
   parameter int CYCLES = 100
) (
   // Clock and reset
   input logic clk,
   input logic rstn,
   // Strobe
   output logic tick
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic next_tick;

   always_comb begin
      next_tick = (cnt == LAST);
      next_cnt = next_tick ? '0 : cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule : scan_divider

// File: event_timer_sequencer.sv
// Sixteen-step event/timer sequencer with an AXI4-Lite register file.
// Assumes one 10 MHz clock; event points are asynchronous pins.
`timescale 1ns/1ps
module event_timer_sequencer
   import etseq_pkg::*;
#(
   parameter int SCAN_CYCLES = TICK_CYCLES
) (
   // Clock and reset
   input logic clk,
   input logic rstn,
   // AXI4-Lite write channels
   input logic [ADDR_W-1:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   // AXI4-Lite read channels
   input logic [ADDR_W-1:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   // Discrete points
   input logic [NUM_POINTS-1:0] stepEventPoint,
   output logic [NUM_OUTS-1:0] coil,
   output logic seqDone
);
   logic scan;
   logic awHeld, wHeld, next_awHeld, next_wHeld;
   logic [ADDR_W-1:0] awAddr, next_awAddr, wrAddr;
   logic [31:0] wData, next_wData, wrData;
   logic [3:0] wStrb, next_wStrb, wrStrb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic awTake, wTake, arTake, doWr;
   logic [32:0] wrWord, rdWord;
   logic [3:0] ctrl, next_ctrl;
   logic [VAL_W-1:0] timebase, next_timebase;
   logic [3:0] presetIdx, next_presetIdx, lastIdx, next_lastIdx;
   logic [NUM_OUTS-1:0] relay, next_relay;
   logic [NUM_OUTS-1:0] pattern [NUM_STEPS];
   logic [NUM_OUTS-1:0] next_pattern [NUM_STEPS];
   logic [31:0] cfgWord [NUM_STEPS];
   logic [31:0] next_cfgWord [NUM_STEPS];
   logic [NUM_POINTS-1:0] evS1, evS2, evS3, evIn, next_evIn;
   seq_state_e state, next_state;
   logic [3:0] stepIdx, next_stepIdx;
   logic [VAL_W-1:0] prescale, next_prescale, stepCnt, next_stepCnt;
   logic jogSeen, next_jogSeen, runSeen, next_runSeen;
   logic [NUM_OUTS-1:0] next_coil;
   logic active, jogRise, gate, met, evVal;
   logic [31:0] curCfg;
   logic [VAL_W-1:0] tbEff, cntLim;
   logic done;

   scan_divider #(
      .CYCLES(SCAN_CYCLES)
   ) uScan (
      .clk(clk),
      .rstn(rstn),
      .tick(scan)
   );

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[8*i+:8] = nw[8*i+:8];
      end
      return r;
   endfunction : mergeBytes

   function automatic logic [VAL_W-1:0] clampVal(input logic [15:0] v);
      return (v > {2'h0, VAL_MAX}) ? VAL_MAX : v[VAL_W-1:0];
   endfunction : clampVal

   // Step numbers 1..16 are stored as index 0..15; out-of-range saturates
   function automatic logic [3:0] stepToIdx(input logic [4:0] n);
      logic [4:0] m;
      m = (n == 5'h00) ? 5'h01 : ((n > 5'h10) ? 5'h10 : n);
      return 4'(m - 5'h01);
   endfunction : stepToIdx

   // Bit 32 marks a mapped address
   function automatic logic [32:0] regRead(input logic [ADDR_W-1:0] a);
      logic [32:0] r;
      r = {1'b1, 32'h0000_0000};
      case (a[7:6])
         PAGE_PATTERN: r[NUM_OUTS-1:0] = pattern[a[5:2]];
         PAGE_STEPCFG: r[31:0] = cfgWord[a[5:2]];
         2'h3: r[32] = 1'b0;
         default: begin
            case ({a[7:2], 2'h0})
               OFF_CTRL: r[3:0] = ctrl;
               OFF_TIMEBASE: r[VAL_W-1:0] = timebase;
               OFF_PRESET: r[4:0] = {1'b0, presetIdx} + 5'h01;
               OFF_LAST: r[4:0] = {1'b0, lastIdx} + 5'h01;
               OFF_STATUS: begin
                  r[4:0] = {1'b0, stepIdx} + 5'h01;
                  r[STAT_DONE_BIT] = done;
               end
               OFF_PRESCALE: r[VAL_W-1:0] = prescale;
               OFF_STEPCNT: r[VAL_W-1:0] = stepCnt;
               OFF_RELAY: r[NUM_OUTS-1:0] = relay;
               OFF_INPUTS: r[NUM_POINTS-1:0] = evIn;
               default: r[32] = 1'b0;
            endcase
         end
      endcase
      return r;
   endfunction : regRead

   // Bus slave: address and data may arrive in either order
   assign awTake = awvalid && awready;
   assign wTake = wvalid && wready;
   assign arTake = arvalid && arready;
   assign wrAddr = awTake ? awaddr : awAddr;
   assign wrData = wTake ? wdata : wData;
   assign wrStrb = wTake ? wstrb : wStrb;
   assign doWr = (awHeld || awTake) && (wHeld || wTake);
   // A process, not an assign, so register changes behind the function are seen
   always_comb begin
      wrWord = regRead(wrAddr);
      rdWord = regRead(araddr);
   end

   always_comb begin
      next_awAddr = wrAddr;
      next_wData = wrData;
      next_wStrb = wrStrb;
      next_awHeld = (awHeld || awTake) && !doWr;
      next_wHeld = (wHeld || wTake) && !doWr;
      next_bvalid = bvalid ? !bready : doWr;
      next_bresp = doWr ? (wrWord[32] ? RESP_OKAY : RESP_SLVERR) : bresp;
      next_awready = !next_awHeld && !next_bvalid;
      next_wready = !next_wHeld && !next_bvalid;
      next_rvalid = rvalid ? !rready : arTake;
      next_rdata = arTake ? rdWord[31:0] : rdata;
      next_rresp = arTake ? (rdWord[32] ? RESP_OKAY : RESP_SLVERR) : rresp;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         awAddr <= next_awAddr;
         wData <= next_wData;
         wStrb <= next_wStrb;
         awready <= next_awready;
         wready <= next_wready;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= next_arready;
         rvalid <= next_rvalid;
         rdata <= next_rdata;
         rresp <= next_rresp;
      end
   end

   // Configuration; read-only addresses accept and drop writes
   always_comb begin
      logic [31:0] wv;
      wv = mergeBytes(wrWord[31:0], wrData, wrStrb);
      next_ctrl = ctrl;
      next_timebase = timebase;
      next_presetIdx = presetIdx;
      next_lastIdx = lastIdx;
      next_relay = relay;
      next_pattern = pattern;
      next_cfgWord = cfgWord;
      if (doWr) begin
         case (wrAddr[7:6])
            PAGE_PATTERN: next_pattern[wrAddr[5:2]] = wv[NUM_OUTS-1:0]; // RL3
            PAGE_STEPCFG: begin
               next_cfgWord[wrAddr[5:2]] = wv & CFG_MASK; // RL4
               next_cfgWord[wrAddr[5:2]][VAL_W-1:0] = clampVal(wv[15:0]); // RL7
            end
            2'h3: ;
            default: begin
               case ({wrAddr[7:2], 2'h0})
                  OFF_CTRL: next_ctrl = wv[3:0];
                  OFF_TIMEBASE: next_timebase = clampVal(wv[15:0]); // RL7
                  OFF_PRESET: next_presetIdx = stepToIdx(wv[4:0]); // RL16
                  OFF_LAST: next_lastIdx = stepToIdx(wv[4:0]); // RL1
                  OFF_RELAY: next_relay = wv[NUM_OUTS-1:0];
                  default: ;
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= RST_CTRL;
         timebase <= RST_TIMEBASE;
         presetIdx <= RST_PRESET;
         lastIdx <= RST_LAST;
         relay <= '0;
         for (int i = 0; i < NUM_STEPS; i++) begin
            pattern[i] <= '0;
            cfgWord[i] <= '0;
         end
      end else begin
         ctrl <= next_ctrl;
         timebase <= next_timebase;
         presetIdx <= next_presetIdx;
         lastIdx <= next_lastIdx;
         relay <= next_relay;
         pattern <= next_pattern;
         cfgWord <= next_cfgWord;
      end
   end

   // Event pins: a change counts once the second and third stages agree
   always_comb begin
      next_evIn = (evS3 & ~(evS2 ^ evS3)) | (evIn & (evS2 ^ evS3));
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         evS1 <= '0;
         evS2 <= '0;
         evS3 <= '0;
         evIn <= '0;
      end else begin
         evS1 <= stepEventPoint;
         evS2 <= evS1;
         evS3 <= evS2;
         evIn <= next_evIn;
      end
   end

   // Sequencer, evaluated only on the scan strobe
   assign done = (state == SEQ_DONE);
   assign curCfg = cfgWord[stepIdx];
   assign cntLim = curCfg[VAL_W-1:0];
   // A zero timebase would stall the prescaler, so it acts as one tick
   assign tbEff = (timebase == '0) ? 14'h0001 : timebase; // RL5

   always_comb begin
      case (curCfg[CFG_EVTYPE_LSB+:2]) // RL11
         EV_INPUT: evVal = evIn[curCfg[CFG_EVIDX_LSB+:4]];
         EV_OUTPUT: evVal = coil[curCfg[CFG_EVIDX_LSB+:4]];
         EV_RELAY: evVal = relay[curCfg[CFG_EVIDX_LSB+:4]];
         default: evVal = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      next_stepIdx = stepIdx;
      next_prescale = prescale;
      next_stepCnt = stepCnt;
      next_jogSeen = jogSeen;
      next_runSeen = runSeen;
      active = 1'b0;
      met = 1'b0;
      jogRise = ctrl[CTRL_JOG_BIT] && !jogSeen;
      gate = !curCfg[CFG_USEEV_BIT] || evVal; // RL21
      if (scan) begin // RL8
         next_jogSeen = ctrl[CTRL_JOG_BIT];
         next_runSeen = ctrl[CTRL_RUN_BIT];
         if (ctrl[CTRL_RUN_BIT]) begin
            if (ctrl[CTRL_RESET_BIT] || !runSeen) begin
               next_state = SEQ_STEP; // RL19
               next_stepIdx = presetIdx; // RL15 RL16 RL17
               next_prescale = '0;
               next_stepCnt = '0;
            end else if (!done) begin
               active = 1'b1;
               if (ctrl[CTRL_START_BIT]) begin // RL17
                  if (curCfg[CFG_USECNT_BIT] && cntLim != '0) begin
                     if (gate) begin // RL12
                        if ({1'b0, prescale} + 15'h0001 >= {1'b0, tbEff}) begin // RL5
                           next_prescale = '0;
                           if ({1'b0, stepCnt} + 15'h0001 >= {1'b0, cntLim}) begin
                              met = 1'b1; // RL6 RL9
                           end else begin
                              next_stepCnt = stepCnt + 14'h0001;
                           end
                        end else begin
                           next_prescale = prescale + 14'h0001;
                        end
                     end
                  end else begin
                     met = gate; // RL21
                  end
               end
               if (met || jogRise) begin // RL18
                  if (stepIdx == lastIdx) begin
                     next_state = SEQ_DONE; // RL19
                  end else begin
                     next_stepIdx = stepIdx + 4'h1; // RL13
                     next_prescale = '0; // RL20
                     next_stepCnt = '0; // RL20
                  end
               end
            end
         end
      end
      next_coil = pattern[next_stepIdx]; // RL2 RL10 RL14
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= SEQ_STEP;
         stepIdx <= RST_PRESET;
         prescale <= '0;
         stepCnt <= '0;
         jogSeen <= 1'b0;
         runSeen <= 1'b0;
         coil <= '0;
         seqDone <= 1'b0;
      end else begin
         state <= next_state;
         stepIdx <= next_stepIdx;
         prescale <= next_prescale;
         stepCnt <= next_stepCnt;
         jogSeen <= next_jogSeen;
         runSeen <= next_runSeen;
         coil <= next_coil;
         seqDone <= (next_state == SEQ_DONE);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic [NUM_OUTS-1:0] curPat;
   assign curPat = pattern[stepIdx];

   a_coil_pattern: assert property (!$past(doWr) |-> coil == curPat) // RL14
      else $error("outputs differ from current step pattern");
   a_scan_only: assert property (!scan |=> $stable(stepIdx) && $stable(prescale) // RL8
      && $stable(stepCnt))
      else $error("sequencer moved without a scan strobe");
   a_start_freeze: assert property (active && !ctrl[CTRL_START_BIT] && !jogRise // RL17
      |=> $stable(stepIdx) && $stable(prescale) && $stable(stepCnt))
      else $error("sequencer moved while start was off");
   a_reset_preset: assert property (scan && ctrl[CTRL_RUN_BIT] && ctrl[CTRL_RESET_BIT] // RL16
      |=> stepIdx == $past(presetIdx) && !seqDone && prescale == '0)
      else $error("reset did not load the preset step");
   a_entry_clear: assert property ($changed(stepIdx) |-> prescale == '0 // RL20
      && stepCnt == '0)
      else $error("timers not cleared on step entry");
   a_event_gate: assert property (active && ctrl[CTRL_START_BIT] && curCfg[CFG_USEEV_BIT] // RL12
      && !evVal && !jogRise |=> $stable(prescale) && $stable(stepIdx))
      else $error("timer ran while step event was false");
   a_jog_advance: assert property (active && jogRise && stepIdx != lastIdx // RL18
      |=> stepIdx == $past(stepIdx) + 4'h1 ##1 coil == $past(pattern[stepIdx]))
      else $error("jog edge did not advance one step");
   a_count_expire: assert property (active && ctrl[CTRL_START_BIT] && gate // RL13
      && curCfg[CFG_USECNT_BIT] && cntLim != '0 && stepIdx != lastIdx
      && prescale + 14'h0001 >= tbEff && stepCnt + 14'h0001 >= cntLim
      |=> stepIdx == $past(stepIdx) + 4'h1)
      else $error("expired count did not advance the step");
   a_done_hold: assert property (seqDone && !(scan && ctrl[CTRL_RUN_BIT] // RL19
      && (ctrl[CTRL_RESET_BIT] || !runSeen)) |=> seqDone && $stable(stepIdx))
      else $error("completion state left without reset");
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before acceptance");

   c_done: cover property (!seqDone ##1 seqDone);
   c_jog: cover property (active && jogRise && !ctrl[CTRL_START_BIT]);
   c_event_wait: cover property (active && ctrl[CTRL_START_BIT] && !gate);
   c_write: cover property (doWr && wTake && !awTake);
endmodule : event_timer_sequencer

// File: event_point_model.sv
// Field model of the discrete event points that feed the sequencer.
// Assumes the bench names the wanted point levels; they reach the pins after an edge.
`timescale 1ns/1ps
module event_point_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Wanted field levels and the pins
   input wire logic [15:0] wanted,
   output logic [15:0] stepEventPoint
);
   // Field switches move after the sampling edge, never on it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stepEventPoint <= 16'h0000;
      end else begin
         stepEventPoint <= wanted;
      end
   end
endmodule : event_point_model

// File: event_timer_sequencer_tb.sv
// Self-checking bench for the event timer sequencer.
// Assumes a 10 MHz clock and a short scan period so the run stays brief.
`timescale 1ns/1ps
module event_timer_sequencer_tb
   import etseq_pkg::*;
;
   localparam int SC = 4;
   localparam int LIMIT = 20000;
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, seqDone;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, bsp;
   logic [15:0] coil, points, wanted;
   int num_errors, tests_run, cyc;

   event_timer_sequencer #(.SCAN_CYCLES(SC)) i_event_timer_sequencer (
      .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .stepEventPoint(points), .coil(coil), .seqDone(seqDone));
   event_point_model i_event_point_model (
      .clk(clk), .rstn(rstn), .wanted(wanted), .stepEventPoint(points));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic results();
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         num_errors++;
         results();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bsp = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   task automatic stat(input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(OFF_STATUS, d, r);
      chk("status", d & 32'h0000_01FF, e);
   endtask : stat

   task automatic waitCoil(input logic [15:0] p, output int t);
      while (coil !== p) @(posedge clk);
      t = cyc;
   endtask : waitCoil

   function automatic logic [15:0] pat(input int s);
      return 16'(s * 16'h0A53);
   endfunction : pat

   function automatic logic [31:0] cfg(input logic [13:0] n, input logic uc,
                                       input logic ue, input logic [3:0] idx, input logic [1:0] ty);
      return {2'h0, ty, idx, 6'h00, ue, uc, 2'h0, n};
   endfunction : cfg

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      chk("coil", coil, 32'h0);
      chk("done", seqDone, 32'h0);
      stat(32'h001);
      rd(OFF_TIMEBASE, d, r);
      chk("timebase", d, 32'h64);
      rd(8'h24, d, r);
      chk("unmapped resp", r, RESP_SLVERR);
      chk("unmapped data", d, 32'h0);
      wr(8'h24, 32'hFFFF_FFFF);
      chk("unmapped wr resp", bsp, RESP_SLVERR);
   endtask : t_reset

   task automatic t_program();
      wr(OFF_TIMEBASE, 32'h2);
      for (int i = 0; i < 16; i++) begin
         wr(8'(8'h40 + 4 * i), {16'h0000, pat(i + 1)});
      end
      wr(8'h80, cfg(14'h1, 1'b1, 1'b0, 4'h0, EV_INPUT));
      wr(8'h84, cfg(14'h3, 1'b1, 1'b0, 4'h0, EV_INPUT));
      wr(8'h88, cfg(14'h2, 1'b1, 1'b1, 4'h5, EV_INPUT));
      wr(8'h8C, cfg(14'h0, 1'b0, 1'b1, 4'h3, EV_RELAY));
      wr(8'h90, cfg(14'h3, 1'b1, 1'b0, 4'h0, EV_INPUT));
      wr(8'h94, cfg(14'h32, 1'b1, 1'b0, 4'h0, EV_INPUT));
      wr(8'hA4, cfg(14'h0, 1'b0, 1'b1, 4'h1, EV_OUTPUT));
      chk("write resp", bsp, RESP_OKAY);
      @(posedge clk);
      chk("step one coil", coil, pat(1));
   endtask : t_program

   task automatic t_timed();
      int t2, t3;
      wr(OFF_CTRL, 32'h9);
      waitCoil(pat(2), t2);
      waitCoil(pat(3), t3);
      chk("timed dwell", t3 - t2, 6 * SC);
   endtask : t_timed

   task automatic t_event();
      int t0, t4;
      repeat (10 * SC) @(posedge clk);
      stat(32'h003);
      wanted <= 16'h0020;
      t0 = cyc;
      waitCoil(pat(4), t4);
      chk("gated dwell", (t4 - t0 >= 3 * SC) && (t4 - t0 <= 4 * SC + 8), 32'h1);
      repeat (3 * SC) @(posedge clk);
      chk("waiting coil", coil, pat(4));
      wr(OFF_RELAY, 32'h8);
      waitCoil(pat(5), t4);
      stat(32'h005);
   endtask : t_event

   task automatic t_freeze();
      logic [31:0] d;
      logic [1:0] r;
      wr(OFF_CTRL, 32'h8);
      repeat (10 * SC) @(posedge clk);
      stat(32'h005);
      wr(OFF_CTRL, 32'hA);
      repeat (2 * SC) @(posedge clk);
      stat(32'h006);
      chk("jog coil", coil, pat(6));
      rd(OFF_STEPCNT, d, r);
      chk("entry count", d, 32'h0);
      wr(OFF_CTRL, 32'h8);
   endtask : t_freeze

   task automatic t_done();
      wr(OFF_PRESET, 32'hA);
      wr(OFF_LAST, 32'hB);
      wr(OFF_CTRL, 32'hC);
      repeat (2 * SC) @(posedge clk);
      stat(32'h00A);
      chk("preset coil", coil, pat(10));
      wr(OFF_CTRL, 32'h9);
      repeat (4 * SC) @(posedge clk);
      chk("done flag", seqDone, 32'h1);
      stat(32'h10B);
      chk("held coil", coil, pat(11));
      wr(OFF_CTRL, 32'hB);
      repeat (2 * SC) @(posedge clk);
      stat(32'h10B);
      wr(OFF_CTRL, 32'hC);
      repeat (2 * SC) @(posedge clk);
      stat(32'h00A);
      chk("done cleared", seqDone, 32'h0);
   endtask : t_done

   initial begin
      rstn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      wanted = 16'h0000;
      cyc = 0;
      num_errors = 0;
      tests_run = 0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_program();
      t_timed();
      t_event();
      t_freeze();
      t_done();
      results();
   end
endmodule : event_timer_sequencer_tb
